/* core/twcrp_pkg.sv */
// twcrp_pkg: constants shared by the three-wire register port and its core-side shadow.
// Assumes nothing about its surroundings; pure definitions.
package twcrp_pkg;

    // serial framing
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned ADDR_W        = 4;
    localparam logic [2:0]  BIT_CNT_LAST  = 3'h7;
    localparam logic [2:0]  BIT_CNT_RESET = 3'h0;

    // command byte layout: address in the upper nibble, format in the lower
    localparam int unsigned CMD_ADDR_MSB  = 7;
    localparam int unsigned CMD_ADDR_LSB  = 4;
    localparam int unsigned CMD_FMT_MSB   = 3;
    localparam int unsigned CMD_FMT_LSB   = 0;

    // transfer format codes
    localparam logic [3:0] FMT_WR_BURST  = 4'h0;
    localparam logic [3:0] FMT_RD_BURST  = 4'h4;
    localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
    localparam logic [3:0] FMT_RD_SINGLE = 4'hc;

    // register offsets (address pointer values)
    localparam logic [3:0] ADDR_WEEKLY_ALARM_DAY_MASK = 4'ha;
    localparam logic [3:0] ADDR_DAILY_ALARM_MINUTE    = 4'hb;
    localparam logic [3:0] ADDR_DAILY_ALARM_HOUR      = 4'hc;

    // implemented field widths; bits above read as zero
    localparam int unsigned DAY_MASK_W = 7;
    localparam int unsigned MINUTE_W   = 7;
    localparam int unsigned HOUR_W     = 6;
    localparam int unsigned HOUR_PM_BIT = 5;

    // values after reset
    localparam logic [6:0] DAY_MASK_RESET = 7'h00;
    localparam logic [6:0] MINUTE_RESET   = 7'h00;
    localparam logic [5:0] HOUR_RESET     = 6'h00;
    localparam logic [7:0] READ_UNMAPPED  = 8'h00;

    // crossing depth into the core clock
    localparam int unsigned SYNC_STAGES = 2;

    // session phase of the serial engine
    typedef enum logic [2:0] {
        TWCRP_CMD       = 3'b000,
        TWCRP_WR_SINGLE = 3'b001,
        TWCRP_WR_BURST  = 3'b010,
        TWCRP_RD_SINGLE = 3'b011,
        TWCRP_RD_BURST  = 3'b100,
        TWCRP_IGNORE    = 3'b101
    } twcrp_phase_t;

endpackage : twcrp_pkg

/* core/twcrp_xfer_if.sv */
// twcrp_xfer_if: carries register contents and a write event from the serial side
// to the core side. Values are held stable between write events.
`timescale 1ns/10ps
interface twcrp_xfer_if;
    logic       wr_toggle;  // flips once per register write
    logic [6:0] day_mask;
    logic [6:0] minute;
    logic [5:0] hour;

    modport link (output wr_toggle, output day_mask, output minute, output hour);
    modport core (input wr_toggle, input day_mask, input minute, input hour);
endinterface : twcrp_xfer_if

/* core/twcrp_shadow.sv */
// twcrp_shadow: core-clock copy of the alarm registers plus weekday match and hour decode.
// Assumes the serial side holds register values stable for several core cycles after
// each toggle, which eight serial clock edges per byte guarantee.
`timescale 1ns/10ps
module twcrp_shadow
    import twcrp_pkg::*;
#(
    parameter int unsigned STAGES = SYNC_STAGES
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       core_en_i,
    twcrp_xfer_if.core      xfer,
    input  wire logic [2:0] day_of_week_i,
    input  wire logic       hour_mode_24_i,
    output logic      [6:0] day_mask_o,
    output logic      [6:0] minute_o,
    output logic      [5:0] hour_o,
    output logic      [5:0] hour24_o,
    output logic            weekly_day_match_o
);

    initial begin
        if (STAGES < 2) $error("twcrp_shadow: STAGES must be at least 2");
    end

    logic [STAGES-1:0] tog_sync;
    logic              tog_seen;
    wire logic         tog_event = tog_sync[STAGES-1] ^ tog_seen;

    // 12-hour to 24-hour bcd: midnight is 12 am, noon is 12 with pm set;
    // built from the core copy, never from the serial-side value, which is not synchronised
    wire logic [4:0] h12_bin   = 5'(hour_o[4] ? 5'd10 : 5'd0) + 5'(hour_o[3:0]);
    wire logic [4:0] h_base    = (h12_bin == 5'd12) ? 5'd0 : h12_bin;
    wire logic [4:0] h24_bin   = h_base + (hour_o[HOUR_PM_BIT] ? 5'd12 : 5'd0);
    wire logic [1:0] h24_tens  = (h24_bin >= 5'd20) ? 2'd2 : ((h24_bin >= 5'd10) ? 2'd1 : 2'd0);
    wire logic [4:0] h24_ones  = h24_bin - (5'(h24_tens) * 5'd10);
    wire logic [5:0] next_h24  = hour_mode_24_i ? hour_o : {h24_tens, h24_ones[3:0]};

    // first stage feeds only the second stage
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tog_sync <= '0;
            tog_seen <= 1'b0;
        end else if (core_en_i) begin
            tog_sync <= {tog_sync[STAGES-2:0], xfer.wr_toggle};
            tog_seen <= tog_sync[STAGES-1];
        end
    end

    // copy on write event; data was stable long before the toggle settled
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            day_mask_o <= DAY_MASK_RESET;
            minute_o   <= MINUTE_RESET;
            hour_o     <= HOUR_RESET;
        end else if (core_en_i && tog_event) begin
            day_mask_o <= xfer.day_mask;
            minute_o   <= xfer.minute;
            hour_o     <= xfer.hour;
        end
    end

    // weekday bit n serves counter value n; all-zero mask never matches
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hour24_o           <= HOUR_RESET;
            weekly_day_match_o <= 1'b0;
        end else if (core_en_i) begin
            hour24_o           <= next_h24;
            weekly_day_match_o <= (day_of_week_i != 3'b111) && day_mask_o[day_of_week_i];
        end
    end

endmodule : twcrp_shadow

/* core/twcrp_port.sv */
// twcrp_port: three-wire serial register port of a clock/calendar device with the
// weekly day mask and daily alarm minute/hour registers it reaches.
// Assumes the host drives chip enable, serial clock and the data line; the serial clock
// runs only inside sessions, and the line level is resolved outside from the output enable sio_oe_o.
`timescale 1ns/10ps

module twcrp_port
    import twcrp_pkg::*;
#(
    parameter int unsigned DATA_W = BYTE_W
) (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       core_en_i,
    input  wire logic       ce_i,
    input  wire logic       sclk_i,
    input  wire logic       sio_i,
    output logic            sio_o,
    output logic            sio_oe_o,
    input  wire logic [2:0] day_of_week_i,
    input  wire logic       hour_mode_24_i,
    output logic      [6:0] weekly_alarm_day_mask_o,
    output logic      [6:0] daily_alarm_minute_o,
    output logic      [5:0] daily_alarm_hour_o,
    output logic      [5:0] daily_alarm_hour24_o,
    output logic            weekly_day_match_o
);

    initial begin
        if (DATA_W != BYTE_W) $error("twcrp_port: DATA_W must equal the byte width");
    end

    twcrp_xfer_if xfer ();

    // --------------------------------------------------------------
    // edge polarity, caught when chip enable rises
    // --------------------------------------------------------------
    logic       sclk_high_at_start;

    // transparent while enable is low, so it already holds the clock level when enable rises;
    // a flop clocked by enable would flip the polarity after the rise and fake a sample edge
    always_latch begin
        if (!reset_n_i) begin
            sclk_high_at_start <= 1'b0;
        end else if (!ce_i) begin
            sclk_high_at_start <= sclk_i;
        end
    end

    // sample edge is the rising edge of this clock, drive edge its falling edge;
    // held high outside sessions so the sample-edge flops never see it pulse between frames
    wire logic  sample_clk = ~(sclk_i ^ sclk_high_at_start) | ~ce_i;

    // engine state dies with the frame: enable low holds it in reset
    wire logic  session_rst_n = ce_i & reset_n_i;

    // --------------------------------------------------------------
    // serial engine state (sample edge)
    // --------------------------------------------------------------
    twcrp_phase_t     phase;
    twcrp_phase_t     next_phase;
    logic [2:0]       bit_cnt;
    logic [6:0]       shift;
    logic [3:0]       addr_ptr;
    logic [3:0]       next_addr;

    // alarm storage, kept across sessions
    logic [6:0]       day_mask;
    logic [6:0]       minute;
    logic [5:0]       hour;
    logic             wr_toggle;

    // --------------------------------------------------------------
    // byte assembly and decode
    // --------------------------------------------------------------
    wire logic [7:0]  rx_byte   = {shift, sio_i};
    wire logic        byte_done = (bit_cnt == BIT_CNT_LAST);
    wire logic [3:0]  cmd_addr  = rx_byte[CMD_ADDR_MSB:CMD_ADDR_LSB];
    wire logic [3:0]  cmd_fmt   = rx_byte[CMD_FMT_MSB:CMD_FMT_LSB];
    wire logic        is_write  = (phase == TWCRP_WR_SINGLE) || (phase == TWCRP_WR_BURST);
    wire logic        is_read   = (phase == TWCRP_RD_SINGLE) || (phase == TWCRP_RD_BURST);
    wire logic        is_burst  = (phase == TWCRP_WR_BURST) || (phase == TWCRP_RD_BURST);
    wire logic        wr_strobe = is_write && byte_done;
    wire logic [3:0]  addr_inc  = addr_ptr + 4'h1;

    // register selects
    wire logic        sel_mask  = (addr_ptr == ADDR_WEEKLY_ALARM_DAY_MASK);
    wire logic        sel_min   = (addr_ptr == ADDR_DAILY_ALARM_MINUTE);
    wire logic        sel_hour  = (addr_ptr == ADDR_DAILY_ALARM_HOUR);

    // read mux; unimplemented bits and unmapped addresses read zero
    wire logic [7:0]  rd_byte   = sel_mask ? {1'b0, day_mask} :
                                  sel_min  ? {1'b0, minute} :
                                  sel_hour ? {2'b00, hour} :
                                  READ_UNMAPPED;

    // format decode for a completed command byte
    twcrp_phase_t     fmt_phase;
    always_comb begin
        case (cmd_fmt)
            FMT_WR_SINGLE: fmt_phase = TWCRP_WR_SINGLE;
            FMT_WR_BURST:  fmt_phase = TWCRP_WR_BURST;
            FMT_RD_SINGLE: fmt_phase = TWCRP_RD_SINGLE;
            FMT_RD_BURST:  fmt_phase = TWCRP_RD_BURST;
            default:       fmt_phase = TWCRP_IGNORE;     // unknown codes idle until enable falls
        endcase
    end

    // phase and pointer advance at each completed byte
    always_comb begin
        next_phase = phase;
        next_addr  = addr_ptr;
        if (byte_done) begin
            case (phase)
                TWCRP_CMD: begin
                    next_phase = fmt_phase;
                    next_addr  = cmd_addr;
                end
                TWCRP_WR_SINGLE,
                TWCRP_RD_SINGLE: begin
                    next_phase = TWCRP_CMD;
                end
                TWCRP_WR_BURST,
                TWCRP_RD_BURST: begin
                    next_addr  = addr_inc;
                end
                default: begin
                    next_phase = phase;
                end
            endcase
        end
    end

    // bit counter and shifter; a partial byte is simply dropped by session reset
    always_ff @(posedge sample_clk or negedge session_rst_n) begin
        if (!session_rst_n) begin
            bit_cnt <= BIT_CNT_RESET;
            shift   <= '0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift   <= rx_byte[6:0];
        end
    end

    // session phase and address pointer
    always_ff @(posedge sample_clk or negedge session_rst_n) begin
        if (!session_rst_n) begin
            phase    <= TWCRP_CMD;
            addr_ptr <= 4'h0;
        end else begin
            phase    <= next_phase;
            addr_ptr <= next_addr;
        end
    end

    // --------------------------------------------------------------
    // alarm registers, written only on a whole data byte
    // --------------------------------------------------------------
    always_ff @(posedge sample_clk or negedge reset_n_i) begin
        if (!reset_n_i) begin
            day_mask <= DAY_MASK_RESET;
            minute   <= MINUTE_RESET;
            hour     <= HOUR_RESET;
        end else if (wr_strobe && ce_i) begin
            if (sel_mask) begin
                day_mask <= rx_byte[DAY_MASK_W-1:0];
            end else if (sel_min) begin
                minute   <= rx_byte[MINUTE_W-1:0];
            end else if (sel_hour) begin
                hour     <= rx_byte[HOUR_W-1:0];
            end
        end
    end

    // one flip per write tells the core side to recopy; toggle rather than pulse
    // because the serial clock may stop right after the last byte
    always_ff @(posedge sample_clk or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_toggle <= 1'b0;
        end else if (wr_strobe && ce_i) begin
            wr_toggle <= ~wr_toggle;
        end
    end

    assign xfer.wr_toggle = wr_toggle;
    assign xfer.day_mask  = day_mask;
    assign xfer.minute    = minute;
    assign xfer.hour      = hour;

    // --------------------------------------------------------------
    // data line drive (drive edge = falling edge of sample_clk)
    // --------------------------------------------------------------
    // bit index counts down from the msb as the sample edges advance
    wire logic [2:0]  tx_index = BIT_CNT_LAST - bit_cnt;
    wire logic        tx_bit   = rd_byte[tx_index];

    // drive only in read phases; released the moment enable drops
    always_ff @(negedge sample_clk or negedge session_rst_n) begin
        if (!session_rst_n) begin
            sio_o    <= 1'b0;
            sio_oe_o <= 1'b0;
        end else begin
            sio_o    <= is_read ? tx_bit : 1'b0;
            sio_oe_o <= is_read;
        end
    end

    // --------------------------------------------------------------
    // core-side copy, weekday match and hour decode
    // --------------------------------------------------------------
    twcrp_shadow #(
        .STAGES (SYNC_STAGES)
    ) u_shadow (
        .core_clk_i         (core_clk_i),
        .reset_n_i          (reset_n_i),
        .core_en_i          (core_en_i),
        .xfer               (xfer),
        .day_of_week_i      (day_of_week_i),
        .hour_mode_24_i     (hour_mode_24_i),
        .day_mask_o         (weekly_alarm_day_mask_o),
        .minute_o           (daily_alarm_minute_o),
        .hour_o             (daily_alarm_hour_o),
        .hour24_o           (daily_alarm_hour24_o),
        .weekly_day_match_o (weekly_day_match_o)
    );

    // burst flag kept for visibility of the pointer policy in waves
    wire logic unused_burst = is_burst;

endmodule : twcrp_port

/* tb/twcrp_assertions.sv */
// twcrp_assertions: port-level checks on the serial register port and its core copies.
// Assumes bind onto twcrp_port; every check samples on the core clock.
`timescale 1ns/10ps
module twcrp_assertions
    import twcrp_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    input wire logic       ce_i,
    input wire logic       sclk_i,
    input wire logic       sio_o,
    input wire logic       sio_oe_o,
    input wire logic [2:0] day_of_week_i,
    input wire logic       hour_mode_24_i,
    input wire logic [6:0] weekly_alarm_day_mask_o,
    input wire logic [6:0] daily_alarm_minute_o,
    input wire logic [5:0] daily_alarm_hour_o,
    input wire logic [5:0] daily_alarm_hour24_o,
    input wire logic       weekly_day_match_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    logic       lvl_q;    // idle clock level seen at enable rise
    logic       sclk_q;
    logic [3:0] smp_cnt;  // sample edges this session, saturating
    logic [7:0] mask_ext;
    logic       day_bit;
    logic [4:0] h_bin;
    logic [4:0] h12;
    logic [4:0] h24;
    logic [1:0] t24;
    logic [5:0] exp24;

    // expected 24-hour value, rebuilt from the stored hour
    assign mask_ext = {1'b0, weekly_alarm_day_mask_o};
    assign day_bit  = mask_ext[day_of_week_i];
    assign h_bin    = 5'(daily_alarm_hour_o[4]) * 5'd10 + 5'(daily_alarm_hour_o[3:0]);
    assign h12      = (h_bin == 5'd12) ? 5'd0 : h_bin;
    assign h24      = h12 + (daily_alarm_hour_o[5] ? 5'd12 : 5'd0);
    assign t24      = (h24 >= 5'd20) ? 2'd2 : ((h24 >= 5'd10) ? 2'd1 : 2'd0);
    assign exp24    = hour_mode_24_i ? daily_alarm_hour_o : {t24, 4'(h24 - 5'(t24) * 5'd10)};

    always_ff @(posedge ce_i) begin
        lvl_q <= sclk_i;
    end

    // counts sample edges; the serial clock is slow enough to be seen every level
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q  <= 1'b0;
            smp_cnt <= 4'h0;
        end else begin
            sclk_q <= sclk_i;
            if (!ce_i) begin
                smp_cnt <= 4'h0;
            end else if (sclk_i != sclk_q && sclk_i == lvl_q && smp_cnt != 4'hf) begin
                smp_cnt <= smp_cnt + 4'h1;
            end
        end
    end

    a_oe_ce_low: assert property (!ce_i |-> !sio_oe_o)
        else $error("data line driven outside a session");
    a_drive_edge: assert property (ce_i && $past(ce_i) && $changed(sio_o) |->
        $changed(sclk_i) && sclk_i != lvl_q) else $error("data bit changed off the drive edge");
    a_oe_rise_edge: assert property ($rose(sio_oe_o) |-> $changed(sclk_i) && sclk_i != lvl_q)
        else $error("line drive began off the drive edge");
    a_oe_fall_edge: assert property ($fell(sio_oe_o) && ce_i |-> $changed(sclk_i) && sclk_i != lvl_q)
        else $error("line released off the drive edge");
    a_cmd_first: assert property (sio_oe_o |-> smp_cnt >= 4'h8)
        else $error("line driven before a full command byte");
    a_day_match: assert property (weekly_day_match_o == $past(day_bit))
        else $error("weekday match disagrees with mask");
    a_mask_zero: assert property ((weekly_alarm_day_mask_o == 7'h00) ##1 (weekly_alarm_day_mask_o == 7'h00)
        |-> !weekly_day_match_o) else $error("weekday match with empty mask");
    a_hour_convert: assert property (daily_alarm_hour24_o == $past(exp24))
        else $error("24-hour hour conversion wrong");
    a_reset_values: assert property ($rose(reset_n_i) |-> weekly_alarm_day_mask_o == 7'h00
        && daily_alarm_minute_o == 7'h00 && daily_alarm_hour_o == 6'h00) else $error("copies not clear after reset");
endmodule : twcrp_assertions

bind twcrp_port twcrp_assertions u_chk (.core_clk_i, .reset_n_i, .ce_i, .sclk_i, .sio_o, .sio_oe_o,
    .day_of_week_i, .hour_mode_24_i, .weekly_alarm_day_mask_o, .daily_alarm_minute_o,
    .daily_alarm_hour_o, .daily_alarm_hour24_o, .weekly_day_match_o);

/* tb/twcrp_host_model.sv */
// twcrp_host_model: host side of the three-wire link, 32 ns serial clock within sessions.
// Assumes the bench resolves the data line from the device enable and this drive.
`timescale 1ns/10ps
module twcrp_host_model (
    output logic      ce_o,
    output logic      sclk_o,
    output logic      sio_drv_o,
    input  wire logic sio_line_i
);
    logic idle_lvl;

    initial begin
        ce_o      = 1'b0;
        sclk_o    = 1'b0;
        sio_drv_o = 1'b0;
        idle_lvl  = 1'b0;
    end

    // clock level at enable rise picks the edge pair
    task automatic open_session(input logic lvl);
        idle_lvl = lvl;
        sclk_o   = lvl;
        #23 ce_o = 1'b1;
        #20;
    endtask : open_session

    // clock stands still; released line flips so no stale value lingers
    task automatic close_session();
        #20 ce_o = 1'b0;
        sio_drv_o = ~sio_drv_o;
        #97;
    endtask : close_session

    // n bits msb first; bit set after drive edge, line read at sample edge
    task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sclk_o = ~idle_lvl;
            #4 sio_drv_o = d[i];
            #12 q[i] = sio_line_i;
            sclk_o = idle_lvl;
            #16;
        end
    endtask : shift
endmodule : twcrp_host_model

/* tb/tb_three_wire_clock_register_port.sv */
// tb_three_wire_clock_register_port: register traffic through the host model.
// Assumes the core/ files and the checker are compiled first.
`timescale 1ns/10ps
module tb_three_wire_clock_register_port
    import twcrp_pkg::*;
;
    logic        core_clk_i     = 1'b0;
    logic        reset_n_i      = 1'b0;
    logic        core_en_i      = 1'b1;  // copy logic always running
    logic [2:0]  day_of_week_i  = 3'h0;
    logic        hour_mode_24_i = 1'b0;
    logic        ce, sclk, sio_drv, sio_o, sio_oe_o, match;
    logic [6:0]  mask, minute;
    logic [5:0]  hour, hour24;
    logic [7:0]  q;
    logic [15:0] p;
    wire         sio_line = sio_oe_o ? sio_o : sio_drv;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;

    always #5 core_clk_i = ~core_clk_i;

    twcrp_port dut (.core_clk_i, .reset_n_i, .core_en_i, .ce_i(ce), .sclk_i(sclk), .sio_i(sio_line),
        .sio_o, .sio_oe_o, .day_of_week_i, .hour_mode_24_i, .weekly_alarm_day_mask_o(mask),
        .daily_alarm_minute_o(minute), .daily_alarm_hour_o(hour), .daily_alarm_hour24_o(hour24),
        .weekly_day_match_o(match));
    twcrp_host_model host (.ce_o(ce), .sclk_o(sclk), .sio_drv_o(sio_drv), .sio_line_i(sio_line));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr1(input logic [3:0] a, input logic [7:0] d, input logic lvl);
        host.open_session(lvl);
        host.shift({a, FMT_WR_SINGLE}, 8, q);
        host.shift(d, 8, q);
        host.close_session();
    endtask : wr1

    task automatic rd1(input logic [3:0] a, input logic [7:0] exp, input logic lvl);
        host.open_session(lvl);
        host.shift({a, FMT_RD_SINGLE}, 8, q);
        host.shift(8'h00, 8, q);
        host.close_session();
        check("read", q, exp);
    endtask : rd1

    // long enough for the two-stage crossing plus decode
    task automatic core_wait();
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask : core_wait

    task automatic match_sweep(input logic [7:0] m);
        for (int d = 0; d < 8; d++) begin
            @(posedge core_clk_i) day_of_week_i <= 3'(d);
            repeat (3) @(posedge core_clk_i);
            #1;
            check("match", {7'h00, match}, {7'h00, m[d]});
        end
    endtask : match_sweep

    // upper byte is written, lower byte is what reads back
    function automatic logic [15:0] pat(input logic [3:0] a);
        case (a)
            ADDR_WEEKLY_ALARM_DAY_MASK: return 16'hd555;
            ADDR_DAILY_ALARM_MINUTE:    return 16'hd959;
            ADDR_DAILY_ALARM_HOUR:      return 16'hf232;
            default:                    return 16'hee00;
        endcase
    endfunction : pat

    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // hang guard well above the few thousand cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            rd1(4'(a), 8'h00, a[0]);
        end
        wr1(ADDR_WEEKLY_ALARM_DAY_MASK, 8'hff, 1'b0);
        rd1(ADDR_WEEKLY_ALARM_DAY_MASK, 8'h7f, 1'b1);
        // burst write from Fh wrapping round to Ch
        host.open_session(1'b1);
        host.shift(8'hf0, 8, q);
        for (int k = 0; k < 14; k++) begin
            p = pat(4'(15 + k));
            host.shift(p[15:8], 8, q);
        end
        host.close_session();
        host.open_session(1'b0);
        host.shift(8'hf4, 8, q);
        for (int k = 0; k < 14; k++) begin
            p = pat(4'(15 + k));
            host.shift(8'h00, 8, q);
            check("burst", q, p[7:0]);
        end
        host.close_session();
        core_wait();
        check("mask", {1'b0, mask}, 8'h55);
        check("minute", {1'b0, minute}, 8'h59);
        check("hourcopy", {2'b00, hour}, 8'h32);
        check("hour24", {2'b00, hour24}, 8'h12);
        match_sweep(8'h55);
        // read, write, read back in one session
        host.open_session(1'b0);
        host.shift({ADDR_DAILY_ALARM_HOUR, FMT_RD_SINGLE}, 8, q);
        host.shift(8'h00, 8, q);
        check("hour", q, 8'h32);
        host.shift({ADDR_DAILY_ALARM_HOUR, FMT_WR_SINGLE}, 8, q);
        host.shift(8'h12, 8, q);
        host.shift({ADDR_DAILY_ALARM_HOUR, FMT_RD_SINGLE}, 8, q);
        host.shift(8'h00, 8, q);
        check("hour", q, 8'h12);
        host.close_session();
        core_wait();
        check("hour24", {2'b00, hour24}, 8'h00);
        wr1(ADDR_DAILY_ALARM_HOUR, 8'h23, 1'b1);
        core_wait();
        check("hour24", {2'b00, hour24}, 8'h15);
        @(posedge core_clk_i) hour_mode_24_i <= 1'b1;
        core_wait();
        check("hour24", {2'b00, hour24}, 8'h23);
        // partial byte, then an unknown format with a write after it
        host.open_session(1'b1);
        host.shift({ADDR_WEEKLY_ALARM_DAY_MASK, FMT_WR_SINGLE}, 8, q);
        host.shift(8'h00, 5, q);
        host.close_session();
        host.open_session(1'b0);
        host.shift(8'ha1, 8, q);
        host.shift({ADDR_WEEKLY_ALARM_DAY_MASK, FMT_WR_SINGLE}, 8, q);
        host.shift(8'h00, 8, q);
        host.close_session();
        rd1(ADDR_WEEKLY_ALARM_DAY_MASK, 8'h55, 1'b0);
        wr1(ADDR_WEEKLY_ALARM_DAY_MASK, 8'h00, 1'b0);
        core_wait();
        match_sweep(8'h00);
        results();
    end
endmodule : tb_three_wire_clock_register_port
